// ===== srcc_map.vh
// Register map, field positions, reset values and encodings of the system
// reset and clock control block.
// Assumes a 32-bit AHB-Lite slave with word-aligned registers.
`ifndef SRCC_MAP_VH
`define SRCC_MAP_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define SRCC_CAUSE_OFS      8'h00
`define SRCC_CAUSE_CLR_OFS  8'h04
`define SRCC_SWRST_OFS      8'h08
`define SRCC_TRIM_CTL_OFS   8'h0c
`define SRCC_TRIM_STAT_OFS  8'h10
`define SRCC_PWMDIV_OFS     8'h14
`define SRCC_SLEEP_CTL_OFS  8'h18
`define SRCC_SLEEP_EN_OFS   8'h1c
`define SRCC_USBPLL_OFS     8'h20
`define SRCC_SRAM_OFS       8'h24
`define SRCC_IRQ_STAT_OFS   8'h28
`define SRCC_IRQ_MASK_OFS   8'h2c

// ****************************************************************
// Reset cause bit positions
// ****************************************************************
`define SRCC_CAUSE_REG_BIT  0
`define SRCC_CAUSE_SW_BIT   1
`define SRCC_CAUSE_WDG_BIT  2
`define SRCC_CAUSE_BOR_BIT  3
`define SRCC_CAUSE_POR_BIT  4
`define SRCC_CAUSE_EXT_BIT  5
`define SRCC_CAUSE_W        6

// ****************************************************************
// Trim control
// ****************************************************************
`define SRCC_TRIM_W          7
`define SRCC_TRIM_NOMINAL    7'h40
`define SRCC_TRIM_MODE_NONE  2'h0
`define SRCC_TRIM_MODE_AUTO  2'h1
`define SRCC_TRIM_MODE_FACT  2'h2
`define SRCC_TRIM_MODE_USER  2'h3
`define SRCC_TRIM_MODE_LSB   8
`define SRCC_REF_KHZ         32
`define SRCC_SYS_KHZ         100000
`define SRCC_REF_WIN         (`SRCC_SYS_KHZ / `SRCC_REF_KHZ)

// ****************************************************************
// PWM ratio encodings (log2 of the ratio)
// ****************************************************************
`define SRCC_PWMDIV_W    3
`define SRCC_PWMDIV_MAX  3'h6
`define SRCC_PWMDIV_RST  3'h0

// ****************************************************************
// Sleep control, interrupts, misc
// ****************************************************************
`define SRCC_NPERIPH       16
`define SRCC_IRQ_SWRST_BIT 0
`define SRCC_IRQ_CAL_BIT   1
`define SRCC_IRQ_CALERR_BIT 2
`define SRCC_IRQ_W         3
`define SRCC_SRAM_BYTES    32'h00008000
`define SRCC_SWRST_KEY     32'h0000a5a5
`define SRCC_SWRST_LEN     8'h10

`endif

// ===== srcc_pwm_div.v
// Power-of-two divider that yields a one-cycle enable for the PWM time base.
// Assumes the select is already validated by the register file.
`timescale 1ns/1ps
`include "srcc_map.vh"

module srcc_pwm_div
(
  input  wire                      hclk,
  input  wire                      hresetn,
  input  wire [`SRCC_PWMDIV_W-1:0] ratio_sel,
  output reg                       pwm_clk_en
);

  reg [5:0] cnt_reg;
  wire [5:0] limit;

  assign limit = (6'h01 << ratio_sel) - 6'h01;

  // Counting system clock edges keeps the PWM rate tied to the system rate.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_reg    <= 6'h00;
      pwm_clk_en <= 1'b0;
    end
    else
    begin
      if (cnt_reg >= limit)
      begin
        cnt_reg    <= 6'h00;
        pwm_clk_en <= 1'b1;
      end
      else
      begin
        cnt_reg    <= cnt_reg + 6'h01;
        pwm_clk_en <= 1'b0;
      end
    end
  end

endmodule

// ===== srcc_top.v
// System reset and clock control: reset cause record, software reset,
// oscillator trim, PWM clock divider, sleep clock gating, USB PLL power.
// Assumes an AHB-Lite master on hclk; reset event inputs are asynchronous.
//
// Overview of operation
// - Cause flags stay set until software clears them or a pin reset.
// - Cause flags of all resets but a pin reset accumulate as a bitwise OR.
// - Six cause flags; a write-one mask clears exactly the named flags.
// - Software reset request resets processor and all peripherals to defaults.
// - Software reset keeps the cause record and sets the software flag.
// - Automatic trim uses the 32 kHz reference only when hibernation is running.
// - Stored-default mode restores the factory trim value.
// - Supplied-value mode takes a 7-bit code; 0x40 is nominal.
// - Codes above nominal slow the oscillator, codes below speed it up.
// - PWM clock is processor clock divided by 1 to 64 in powers of two.
// - Selected PWM ratio is readable as one of seven encodings.
// - PWM clock follows the system clock rate.
// - Gating on: during sleep only sleep-enabled peripherals keep clocks and may wake.
// - Gating off: every peripheral keeps running during sleep.
// - USB PLL power-down stops the PHY; USB registers stay reachable.
// - Total SRAM capacity in bytes is readable.
// - Sleep settings are kept while gating is off but have no effect.
`timescale 1ns/1ps
`include "srcc_map.vh"

module srcc_top
#(
  parameter [`SRCC_TRIM_W-1:0] FACTORY_TRIM = `SRCC_TRIM_NOMINAL
)
(
  input  wire                     hclk,
  input  wire                     hresetn,
  input  wire                     hsel,
  input  wire [31:0]              haddr,
  input  wire [1:0]               htrans,
  input  wire                     hwrite,
  input  wire [2:0]               hsize,
  input  wire [31:0]              hwdata,
  input  wire                     hready,
  output wire                     hreadyout,
  output wire                     hresp,
  output reg  [31:0]              hrdata,
  input  wire                     regulator_reset_event,
  input  wire                     watchdog_reset_event,
  input  wire                     brownout_reset_event,
  input  wire                     power_on_reset_event,
  input  wire                     pin_reset_event,
  output reg                      sys_reset_n,
  input  wire                     hib_present,
  input  wire                     hib_enabled,
  input  wire                     hib_rtc_running,
  input  wire                     ref_32k,
  input  wire                     osc_slow,
  output reg  [`SRCC_TRIM_W-1:0]  osc_trim,
  output wire                     pwm_clk_en,
  input  wire                     cpu_sleeping,
  input  wire [`SRCC_NPERIPH-1:0] periph_run_en,
  input  wire [`SRCC_NPERIPH-1:0] periph_wake_req,
  output wire [`SRCC_NPERIPH-1:0] periph_clk_en,
  output wire                     cpu_wake,
  output wire                     usb_pll_power,
  output wire                     usb_phy_enable,
  output wire                     irq
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  reg  [5:0] evt_s1_reg;
  reg  [5:0] evt_s2_reg;
  reg  [5:0] evt_s3_reg;
  reg  [5:0] ctl_s1_reg;
  reg  [5:0] ctl_s2_reg;
  wire [5:0] evt_raw;
  wire [5:0] evt_rise;

  assign evt_raw = {pin_reset_event, power_on_reset_event, brownout_reset_event,
                    watchdog_reset_event, 1'b0, regulator_reset_event};

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      evt_s1_reg <= 6'h00;
      evt_s2_reg <= 6'h00;
      evt_s3_reg <= 6'h00;
      ctl_s1_reg <= 6'h00;
      ctl_s2_reg <= 6'h00;
    end
    else
    begin
      evt_s1_reg <= evt_raw;
      evt_s2_reg <= evt_s1_reg;
      evt_s3_reg <= evt_s2_reg;
      ctl_s1_reg <= {osc_slow, ref_32k, cpu_sleeping, hib_rtc_running,
                     hib_enabled, hib_present};
      ctl_s2_reg <= ctl_s1_reg;
    end
  end

  assign evt_rise = evt_s2_reg & ~evt_s3_reg;

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  reg        wr_pend_reg;
  reg [7:0]  wr_addr_reg;
  reg        rd_pend_reg;
  reg [7:0]  rd_addr_reg;
  wire       acc;
  wire       wr_en;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign acc       = hsel & hready & htrans[1];
  assign wr_en     = wr_pend_reg;

  function is_wr;
    input [7:0] a;
    input [7:0] ofs;
    begin
      is_wr = wr_en && (a == ofs);
    end
  endfunction

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [`SRCC_CAUSE_W-1:0]  cause_reg;
  reg [`SRCC_CAUSE_W-1:0]  cause_next;
  reg [1:0]                trim_mode_reg;
  reg [`SRCC_TRIM_W-1:0]   trim_user_reg;
  reg                      cal_busy_reg;
  reg                      cal_err_reg;
  reg [`SRCC_PWMDIV_W-1:0] pwm_clock_ratio_select;
  reg                      gate_en_reg;
  reg [`SRCC_NPERIPH-1:0]  sleep_en_reg;
  reg                      usb_pll_reg;
  reg [`SRCC_IRQ_W-1:0]    irq_stat_reg;
  reg [`SRCC_IRQ_W-1:0]    irq_mask_reg;
  reg [7:0]                swrst_cnt_reg;
  reg                      swrst_pend_reg;
  reg [`SRCC_IRQ_W-1:0]    irq_set;
  reg                      cal_done;
  reg                      cal_fail;

  // The cause record lives under hresetn only; software reset only sets its own flag in it.
  always @*
  begin
    cause_next = cause_reg | evt_rise;
    if (evt_rise[`SRCC_CAUSE_EXT_BIT])
      cause_next = 6'h20;
    if (swrst_pend_reg && swrst_cnt_reg == 8'h00)
      cause_next[`SRCC_CAUSE_SW_BIT] = 1'b1;
    if (is_wr(wr_addr_reg, `SRCC_CAUSE_CLR_OFS))
      cause_next = cause_next & ~(hwdata[5:0] & ~(evt_rise |
                   {4'h0, swrst_pend_reg && swrst_cnt_reg == 8'h00, 1'b0}));
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cause_reg <= 6'h00;
    else
      cause_reg <= cause_next;
  end

  // Software reset: pulses sys_reset_n low for a fixed count of cycles.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      swrst_pend_reg <= 1'b0;
      swrst_cnt_reg  <= 8'h00;
      sys_reset_n    <= 1'b1;
    end
    else if (swrst_pend_reg)
    begin
      sys_reset_n <= 1'b0;
      if (swrst_cnt_reg == `SRCC_SWRST_LEN)
      begin
        swrst_pend_reg <= 1'b0;
        sys_reset_n    <= 1'b1;
      end
      else
        swrst_cnt_reg <= swrst_cnt_reg + 8'h01;
    end
    else if (is_wr(wr_addr_reg, `SRCC_SWRST_OFS) && hwdata == `SRCC_SWRST_KEY)
    begin
      swrst_pend_reg <= 1'b1;
      swrst_cnt_reg  <= 8'h00;
    end
  end

  // ****************************************************************
  // Automatic trim: step once per ref period until 17 ref periods are counted
  // ****************************************************************
  reg        ref_d_reg;
  reg [15:0] win_cnt_reg;
  wire       ref_rise;
  wire       auto_ok;

  assign ref_rise = ctl_s2_reg[4] & ~ref_d_reg;
  assign auto_ok  = ctl_s2_reg[0] & ctl_s2_reg[1] & ctl_s2_reg[2];

  // Trim is nudged one step per reference period: a code above nominal slows
  // the oscillator, so a slow oscillator steps the code down.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ref_d_reg   <= 1'b0;
      win_cnt_reg <= 16'h0000;
      osc_trim    <= `SRCC_TRIM_NOMINAL;
      cal_done    <= 1'b0;
      cal_fail    <= 1'b0;
    end
    else
    begin
      ref_d_reg <= ctl_s2_reg[4];
      cal_done  <= 1'b0;
      cal_fail  <= 1'b0;
      if (!sys_reset_n)
        osc_trim <= FACTORY_TRIM;
      else if (is_wr(wr_addr_reg, `SRCC_TRIM_CTL_OFS))
      begin
        case (hwdata[9:8])
          `SRCC_TRIM_MODE_FACT: osc_trim <= FACTORY_TRIM;
          `SRCC_TRIM_MODE_USER: osc_trim <= hwdata[6:0];
          `SRCC_TRIM_MODE_AUTO: cal_fail <= ~auto_ok;
          default: osc_trim <= osc_trim;
        endcase
        win_cnt_reg <= 16'h0000;
      end
      else if (cal_busy_reg && ref_rise)
      begin
        if (ctl_s2_reg[5] && osc_trim != 7'h00)
          osc_trim <= osc_trim - 7'h01;
        else if (!ctl_s2_reg[5] && osc_trim != 7'h7f)
          osc_trim <= osc_trim + 7'h01;
        if (win_cnt_reg == 16'h0010)
          cal_done <= 1'b1;
        win_cnt_reg <= win_cnt_reg + 16'h0001;
      end
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      trim_mode_reg          <= `SRCC_TRIM_MODE_NONE;
      trim_user_reg          <= `SRCC_TRIM_NOMINAL;
      cal_busy_reg           <= 1'b0;
      cal_err_reg            <= 1'b0;
      pwm_clock_ratio_select <= `SRCC_PWMDIV_RST;
      gate_en_reg            <= 1'b0;
      sleep_en_reg           <= {`SRCC_NPERIPH{1'b0}};
      usb_pll_reg            <= 1'b1;
      irq_mask_reg           <= 3'h0;
    end
    else if (!sys_reset_n)
    begin
      trim_mode_reg          <= `SRCC_TRIM_MODE_NONE;
      trim_user_reg          <= `SRCC_TRIM_NOMINAL;
      cal_busy_reg           <= 1'b0;
      cal_err_reg            <= 1'b0;
      pwm_clock_ratio_select <= `SRCC_PWMDIV_RST;
      gate_en_reg            <= 1'b0;
      sleep_en_reg           <= {`SRCC_NPERIPH{1'b0}};
      usb_pll_reg            <= 1'b1;
      irq_mask_reg           <= 3'h0;
    end
    else
    begin
      if (is_wr(wr_addr_reg, `SRCC_TRIM_CTL_OFS))
      begin
        trim_mode_reg <= hwdata[9:8];
        trim_user_reg <= hwdata[6:0];
        cal_busy_reg  <= (hwdata[9:8] == `SRCC_TRIM_MODE_AUTO) && auto_ok;
        cal_err_reg   <= (hwdata[9:8] == `SRCC_TRIM_MODE_AUTO) && !auto_ok;
      end
      else if (cal_done || (cal_busy_reg && !auto_ok))
        cal_busy_reg <= 1'b0;
      // Out-of-range encodings are ignored so the readback stays legal.
      if (is_wr(wr_addr_reg, `SRCC_PWMDIV_OFS) && hwdata[2:0] <= `SRCC_PWMDIV_MAX)
        pwm_clock_ratio_select <= hwdata[2:0];
      if (is_wr(wr_addr_reg, `SRCC_SLEEP_CTL_OFS))
        gate_en_reg <= hwdata[0];
      if (is_wr(wr_addr_reg, `SRCC_SLEEP_EN_OFS))
        sleep_en_reg <= hwdata[`SRCC_NPERIPH-1:0];
      if (is_wr(wr_addr_reg, `SRCC_USBPLL_OFS))
        usb_pll_reg <= hwdata[0];
      if (is_wr(wr_addr_reg, `SRCC_IRQ_MASK_OFS))
        irq_mask_reg <= hwdata[2:0];
    end
  end

  // ****************************************************************
  // Interrupt status: set wins over a write-one clear
  // ****************************************************************
  always @*
  begin
    irq_set = 3'h0;
    irq_set[`SRCC_IRQ_SWRST_BIT]  = swrst_pend_reg && swrst_cnt_reg == 8'h00;
    irq_set[`SRCC_IRQ_CAL_BIT]    = cal_done;
    irq_set[`SRCC_IRQ_CALERR_BIT] = cal_fail;
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_stat_reg <= 3'h0;
    else if (is_wr(wr_addr_reg, `SRCC_IRQ_STAT_OFS))
      irq_stat_reg <= (irq_stat_reg & ~hwdata[2:0]) | irq_set;
    else
      irq_stat_reg <= irq_stat_reg | irq_set;
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ****************************************************************
  // Bus phases and read mux
  // ****************************************************************
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= 8'h00;
    end
    else
    begin
      wr_pend_reg <= acc & hwrite;
      rd_pend_reg <= acc & ~hwrite;
      if (acc)
      begin
        wr_addr_reg <= {haddr[7:2], 2'b00};
        rd_addr_reg <= {haddr[7:2], 2'b00};
      end
    end
  end

  // Read data is registered at the address phase so it stands in the data phase.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (acc && !hwrite)
    begin
      case ({haddr[7:2], 2'b00})
        `SRCC_CAUSE_OFS:     hrdata <= {26'h0, cause_reg};
        `SRCC_TRIM_CTL_OFS:  hrdata <= {22'h0, trim_mode_reg, 1'b0, trim_user_reg};
        `SRCC_TRIM_STAT_OFS: hrdata <= {22'h0, cal_err_reg, cal_busy_reg,
                                        1'b0, osc_trim};
        `SRCC_PWMDIV_OFS:    hrdata <= {29'h0, pwm_clock_ratio_select};
        `SRCC_SLEEP_CTL_OFS: hrdata <= {31'h0, gate_en_reg};
        `SRCC_SLEEP_EN_OFS:  hrdata <= {16'h0, sleep_en_reg};
        `SRCC_USBPLL_OFS:    hrdata <= {31'h0, usb_pll_reg};
        `SRCC_SRAM_OFS:      hrdata <= `SRCC_SRAM_BYTES;
        `SRCC_IRQ_STAT_OFS:  hrdata <= {29'h0, irq_stat_reg};
        `SRCC_IRQ_MASK_OFS:  hrdata <= {29'h0, irq_mask_reg};
        default:             hrdata <= 32'h00000000;
      endcase
    end
  end

  // ****************************************************************
  // Sleep gating, USB PLL, PWM divider
  // ****************************************************************
  wire sleeping;
  wire [`SRCC_NPERIPH-1:0] sleep_keep;

  assign sleeping   = ctl_s2_reg[3];
  // With gating off the sleep enables are held but ignored.
  assign sleep_keep = gate_en_reg ? sleep_en_reg : {`SRCC_NPERIPH{1'b1}};
  assign periph_clk_en = periph_run_en & (sleeping ? sleep_keep : {`SRCC_NPERIPH{1'b1}});
  assign cpu_wake   = sleeping & |(periph_wake_req & periph_clk_en);

  // Only the PHY depends on the PLL; the USB register clock is not gated here.
  assign usb_pll_power  = usb_pll_reg;
  assign usb_phy_enable = usb_pll_reg;

  srcc_pwm_div u_pwm_div
  (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .ratio_sel  (pwm_clock_ratio_select),
    .pwm_clk_en (pwm_clk_en)
  );

endmodule

// ===== srcc_checker.sv
// Concurrent checks on the ports of the reset and clock control block.
// Assumes the offsets and encodings of srcc_map.vh and a zero-wait slave.
`timescale 1ns/1ps
`include "srcc_map.vh"

module srcc_checker
#(
  parameter [6:0] FACTORY_TRIM = 7'h40
)
(
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire [31:0] hrdata,
  input wire        sys_reset_n,
  input wire [6:0]  osc_trim,
  input wire        cpu_sleeping,
  input wire [15:0] periph_run_en,
  input wire [15:0] periph_clk_en,
  input wire        usb_pll_power,
  input wire        usb_phy_enable
);
  logic [7:0] low_cnt;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ****************************************************************
  // Helper logic
  // ****************************************************************
  // The pulse length is counted here because a repetition that long is too slow to unroll.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      low_cnt <= 8'h00;
    else if (!sys_reset_n)
      low_cnt <= low_cnt + 8'h01;
    else
      low_cnt <= 8'h00;
  end

  sequence ap(bit w, logic [7:0] o);
    hsel && hready && htrans[1] && (hwrite == w) && (haddr == {24'h0, o}) && sys_reset_n;
  endsequence

  property p_user;
    logic [6:0] c;
    (ap(1'b1, `SRCC_TRIM_CTL_OFS) ##1 (hwdata[9:8] == 2'h3 && sys_reset_n, c = hwdata[6:0]))
      |-> ##[1:2] osc_trim == c;
  endproperty

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_swrst_start: assert property (
    ap(1'b1, `SRCC_SWRST_OFS) ##1 hwdata == `SRCC_SWRST_KEY |-> ##[1:3] !sys_reset_n)
    else $error("software reset did not start");
  a_swrst_len: assert property ($rose(sys_reset_n) |-> low_cnt == `SRCC_SWRST_LEN)
    else $error("software reset pulse length wrong");
  a_trim_user: assert property (p_user)
    else $error("supplied trim code not applied");
  a_trim_fact: assert property (
    ap(1'b1, `SRCC_TRIM_CTL_OFS) ##1 (hwdata[9:8] == 2'h2 && sys_reset_n)
      |-> ##[1:2] osc_trim == FACTORY_TRIM)
    else $error("stored trim not restored");
  a_sram_read: assert property (
    ap(1'b0, `SRCC_SRAM_OFS) |-> ##1 hrdata == `SRCC_SRAM_BYTES)
    else $error("memory size read wrong");
  a_clk_subset: assert property ((periph_clk_en & ~periph_run_en) == 16'h0)
    else $error("clock given to a stopped peripheral");
  a_awake_all: assert property (
    !cpu_sleeping [*4] |-> periph_clk_en == periph_run_en)
    else $error("peripheral clock gated while awake");
  a_phy_pll: assert property (!usb_pll_power |-> !usb_phy_enable)
    else $error("phy enabled without pll power");
endmodule

bind srcc_top srcc_checker #(.FACTORY_TRIM(FACTORY_TRIM)) u_srcc_checker (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .sys_reset_n(sys_reset_n), .osc_trim(osc_trim),
  .cpu_sleeping(cpu_sleeping), .periph_run_en(periph_run_en),
  .periph_clk_en(periph_clk_en), .usb_pll_power(usb_pll_power),
  .usb_phy_enable(usb_phy_enable));

// ===== tb_top.sv
// Self-checking bench for the reset and clock control block.
// Assumes srcc_map.vh and the bus master as the only driver of the slave.
`timescale 1ns/1ps
`include "srcc_map.vh"

module tb_top;
  localparam [6:0] FT = 7'h35;
  logic        hclk, hresetn, hsel, hwrite, ref_32k, osc_slow, cpu_sleeping;
  logic        hib_p, hib_e, hib_r;
  logic [31:0] haddr, hwdata, rd, m, se, rr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [4:0]  ev;
  logic [15:0] run_en, wake_req;
  wire         hreadyout, hresp, sys_reset_n, pwm_clk_en, cpu_wake, usb_pwr, usb_phy, irq;
  wire  [31:0] hrdata;
  wire  [6:0]  osc_trim;
  wire  [15:0] clk_en;
  int          error_cnt, check_count, n;

  srcc_top #(.FACTORY_TRIM(FT)) u_srcc_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .regulator_reset_event(ev[0]), .watchdog_reset_event(ev[1]),
    .brownout_reset_event(ev[2]), .power_on_reset_event(ev[3]),
    .pin_reset_event(ev[4]), .sys_reset_n(sys_reset_n), .hib_present(hib_p),
    .hib_enabled(hib_e), .hib_rtc_running(hib_r), .ref_32k(ref_32k),
    .osc_slow(osc_slow), .osc_trim(osc_trim), .pwm_clk_en(pwm_clk_en),
    .cpu_sleeping(cpu_sleeping), .periph_run_en(run_en), .periph_wake_req(wake_req),
    .periph_clk_en(clk_en), .cpu_wake(cpu_wake), .usb_pll_power(usb_pwr),
    .usb_phy_enable(usb_phy), .irq(irq));

  always #5 hclk = ~hclk;

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task test_done;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // The slave is zero-wait, but the master still waits on the ready it samples.
  task wait_ready;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        chk("bus_ready", 0, 1);
        test_done;
      end
      @(posedge hclk);
    end
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    wait_ready;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready;
    rd = hrdata;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(name, rd, exp);
  endtask

  task pulse(input int k);
    @(posedge hclk);
    ev[k] <= 1'b1;
    repeat (6) @(posedge hclk);
    ev[k] <= 1'b0;
    repeat (6) @(posedge hclk);
  endtask

  task wait_rst(input logic v);
    n = 0;
    while (sys_reset_n !== v)
    begin
      @(posedge hclk);
      n++;
      if (n > 60)
      begin
        chk("sys_reset_wait", 0, 1);
        test_done;
      end
    end
  endtask

  task gap(input int k);
    n = 0;
    while (pwm_clk_en !== 1'b1 && n < 200)
    begin
      @(negedge hclk);
      n++;
    end
    n = 0;
    do
    begin
      @(negedge hclk);
      n++;
    end while (pwm_clk_en !== 1'b1 && n < 200);
    chk("pwm_gap", n, 32'h1 << k);
    if (n >= 200)
      test_done;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 2;
    hwdata = 0; ev = 0; hib_p = 0; hib_e = 0; hib_r = 0; ref_32k = 0; osc_slow = 0;
    cpu_sleeping = 0; run_en = 0; wake_req = 0; error_cnt = 0; check_count = 0;
    m = $urandom(55638);
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    chk("trim_rst", osc_trim, 32'h40);
    rdc("sram", `SRCC_SRAM_OFS, 32'h8000);
    rdc("unmapped", 8'h30, 32'h0);
    rdc("usb_rst", `SRCC_USBPLL_OFS, 32'h1);
    $display("reset values done");

    wr(`SRCC_CAUSE_CLR_OFS, 32'h3f);
    rdc("cause_clr", `SRCC_CAUSE_OFS, 32'h0);
    for (int k = 0; k < 4; k++) pulse(k);
    rdc("cause_or", `SRCC_CAUSE_OFS, 32'h1d);
    m = $urandom & 32'h3f;
    wr(`SRCC_CAUSE_CLR_OFS, m);
    rdc("cause_mask", `SRCC_CAUSE_OFS, 32'h1d & ~m);
    pulse(4);
    rdc("cause_pin", `SRCC_CAUSE_OFS, 32'h20);
    $display("reset cause done");

    wr(`SRCC_PWMDIV_OFS, 32'h3);
    wr(`SRCC_SLEEP_EN_OFS, 32'hff);
    wr(`SRCC_SWRST_OFS, 32'h1234);
    repeat (3) @(negedge hclk);
    chk("swrst_refused", sys_reset_n, 32'h1);
    wr(`SRCC_SWRST_OFS, `SRCC_SWRST_KEY);
    wait_rst(1'b0);
    wait_rst(1'b1);
    rdc("pwm_swrst", `SRCC_PWMDIV_OFS, 32'h0);
    rdc("sleep_swrst", `SRCC_SLEEP_EN_OFS, 32'h0);
    rdc("cause_sw", `SRCC_CAUSE_OFS, 32'h22);
    chk("irq_masked", irq, 32'h0);
    wr(`SRCC_IRQ_MASK_OFS, 32'h7);
    @(negedge hclk);
    chk("irq_raised", irq, 32'h1);
    rdc("irq_stat", `SRCC_IRQ_STAT_OFS, 32'h1);
    wr(`SRCC_IRQ_STAT_OFS, 32'h1);
    @(negedge hclk);
    chk("irq_cleared", irq, 32'h0);
    $display("software reset done");

    for (int k = 0; k < 7; k++)
    begin
      wr(`SRCC_PWMDIV_OFS, k);
      rdc("pwm_rd", `SRCC_PWMDIV_OFS, k);
      gap(k);
    end
    wr(`SRCC_PWMDIV_OFS, 32'h7);
    rdc("pwm_bad", `SRCC_PWMDIV_OFS, 32'h6);
    $display("pwm divider done");

    se = $urandom & 32'h7f;
    wr(`SRCC_TRIM_CTL_OFS, 32'h300 | se);
    repeat (2) @(negedge hclk);
    chk("trim_user", osc_trim, se);
    wr(`SRCC_TRIM_CTL_OFS, 32'h200);
    repeat (2) @(negedge hclk);
    chk("trim_fact", osc_trim, FT);
    @(posedge hclk);
    hib_p <= 1'b1;
    hib_e <= 1'b1;
    wr(`SRCC_TRIM_CTL_OFS, 32'h100);
    repeat (8) @(posedge hclk);
    rdc("auto_refused", `SRCC_IRQ_STAT_OFS, 32'h4);
    chk("trim_kept", osc_trim, FT);
    hib_r <= 1'b1;
    osc_slow <= 1'b1;
    wr(`SRCC_IRQ_STAT_OFS, 32'h7);
    wr(`SRCC_TRIM_CTL_OFS, 32'h100);
    repeat (50)
    begin
      repeat (4) @(posedge hclk);
      ref_32k <= ~ref_32k;
    end
    repeat (4) @(negedge hclk);
    chk("trim_auto", osc_trim, FT - 7'd17);
    rdc("auto_done", `SRCC_IRQ_STAT_OFS, 32'h2);
    $display("trim done");

    se = ($urandom & 32'hffff) | 32'h1;
    rr = ($urandom & 32'hffff) | 32'h1;
    wr(`SRCC_SLEEP_CTL_OFS, 32'h1);
    wr(`SRCC_SLEEP_EN_OFS, se);
    run_en <= rr[15:0];
    cpu_sleeping <= 1'b1;
    wake_req <= rr[15:0] & se[15:0];
    repeat (4) @(negedge hclk);
    chk("clk_gated", clk_en, rr & se);
    chk("wake_on", cpu_wake, |(rr & se));
    @(posedge hclk);
    wake_req <= ~se[15:0];
    repeat (4) @(negedge hclk);
    chk("wake_off", cpu_wake, 32'h0);
    wr(`SRCC_SLEEP_CTL_OFS, 32'h0);
    repeat (4) @(negedge hclk);
    chk("clk_ungated", clk_en, rr & 32'hffff);
    rdc("sleep_kept", `SRCC_SLEEP_EN_OFS, se);
    cpu_sleeping <= 1'b0;
    $display("sleep gating done");

    wr(`SRCC_USBPLL_OFS, 32'h0);
    @(negedge hclk);
    chk("usb_pll_off", usb_pwr, 32'h0);
    chk("usb_phy_off", usb_phy, 32'h0);
    rdc("usb_rd", `SRCC_USBPLL_OFS, 32'h0);
    $display("usb pll done");
    test_done;
  end
endmodule
